// file: core/rtc_bcd_inc.sv
/*
  One BCD counter digit pair: increments a packed two-digit BCD value and
  wraps to a given low value after a given high value.
  Assumes both values are legal BCD.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_bcd_inc (
  // Count in and limits
  input wire logic [7:0] val_i,
  input wire logic [7:0] last_i,
  input wire logic [7:0] first_i,
  // Result
  output logic [7:0] next_o,
  output logic wrap_o
);
  always_comb begin
    wrap_o = (val_i == last_i);
    if (wrap_o) begin
      next_o = first_i;
    end else if (val_i[3:0] == 4'h9) begin
      next_o = {val_i[7:4] + 4'h1, 4'h0};
    end else begin
      next_o = {val_i[7:4], val_i[3:0] + 4'h1};
    end
  end
endmodule : rtc_bcd_inc
`default_nettype wire

// file: core/rtc_core.sv
/*
  Calendar clock register block: eight byte registers (control, seconds
  through year) in front of a running BCD counter chain with calibration.
  Assumes a synchronous byte-wide bus already decoded to this block
  (select, write strobe, 19-bit address) and a one-cycle osc_tick_i pulse
  at the oscillator rate, synchronous to clk_i.
*/
// Notes on behaviour
// - Halt bit set: time registers stop copying from counters.
// - While halted, registers hold the halt-time value; counters keep running.
// - A refresh loads all time registers in the same cycle.
// - A halt arriving during a refresh lets the refresh finish first.
// - After halt clears, the first tick is skipped; the next refresh comes at the tick after it.
// - Transfer bit set also suspends refreshes so software can load time.
// - Clearing transfer bit copies all seven registers into the counters.
// - After transfer clears, first refresh comes about one second later.
// - Reset clears transfer and halt bits.
// - Writing one to the oscillator-stop bit halts the oscillator any time.
// - Clearing oscillator-stop restarts the oscillator after about one second.
// - Oscillator-stop writes act without the transfer bit set.
// - Timebase is a 32,768 Hz oscillator divided to one second.
// - Calibration adds or drops counts at the divide-by-256 stage.
// - Calibration magnitude is unsigned 0..31 in control bits 4..0.
// - Control bit 5: one slows the clock, zero speeds it.
// - Correction repeats every 64 minutes; first 62 eligible, one second each.
// - Adjusted second: minus 128 or plus 256 oscillator cycles.
// - Magnitude N adjusts the first 2N minutes of each cycle.
`timescale 1ns/100ps
`default_nettype none
module rtc_core #(
  parameter int OSC_HZ = rtc_pkg::OSC_HZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Oscillator tick
  input wire logic osc_tick_i,
  // Register bus
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Status
  output logic osc_run_o,
  output logic sec_pulse_o
);
  // Registers seen by software
  logic [7:0] ctrl_q;
  logic osc_halt_bit_q;
  logic [7:0] r_sec_q, r_min_q, r_hour_q, r_wday_q, r_date_q, r_month_q, r_year_q;
  // Actual counters
  logic [7:0] c_sec_q, c_min_q, c_hour_q, c_wday_q, c_date_q, c_month_q, c_year_q;
  logic [15:0] pre_q;
  logic [7:0] stage_q;
  logic [8:0] trim_q;
  logic trim_pos_q;
  logic [5:0] cal_min_q;
  logic adj_done_q;
  logic [1:0] start_cnt_q;
  logic osc_run_q;
  logic sec_tick;
  logic xfer_fall;
  logic wr_ctrl, wr_sec;

  typedef enum logic [1:0] {RTC_IDLE, RTC_LOAD, RTC_WAIT} rtc_refresh_t;
  rtc_refresh_t ref_q;
  logic holdoff_q;

  assign wr_ctrl = sel_i && wr_i && (addr_i == rtc_pkg::ADDR_CTRL);
  assign wr_sec = sel_i && wr_i && (addr_i == rtc_pkg::ADDR_SEC);
  assign xfer_fall = wr_ctrl && ctrl_q[rtc_pkg::CTRL_XFER_BIT]
    && !wdata_i[rtc_pkg::CTRL_XFER_BIT];

  // Control register; power-up clears transfer and halt
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_i;
    end
  end

  // Oscillator stop: direct write, no transfer bit needed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_halt_bit_q <= 1'b0;
    end else if (wr_sec) begin
      osc_halt_bit_q <= wdata_i[rtc_pkg::SEC_OSC_HALT_BIT];
    end
  end

  // Restart delay: about one second of oscillator ticks after stop clears
  logic [15:0] start_div_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_run_q <= 1'b1;
      start_cnt_q <= 2'h0;
      start_div_q <= 16'h0000;
    end else if (osc_halt_bit_q) begin
      osc_run_q <= 1'b0;
      start_cnt_q <= 2'h0;
      start_div_q <= 16'h0000;
    end else if (!osc_run_q && osc_tick_i) begin
      if (start_div_q == 16'(OSC_HZ - 1)) begin
        start_div_q <= 16'h0000;
        if (start_cnt_q == 2'(rtc_pkg::OSC_START_SEC - 1)) begin
          osc_run_q <= 1'b1;
        end else begin
          start_cnt_q <= start_cnt_q + 2'h1;
        end
      end else begin
        start_div_q <= start_div_q + 16'h0001;
      end
    end
  end

  // Divider chain: prescale by 256, then 128 stage ticks make one second.
  // Trim adds or removes oscillator cycles ahead of the /256 stage.
  logic adj_min, blank, swallow, pre_end;
  assign adj_min = (cal_min_q < {ctrl_q[4:0], 1'b0});
  assign blank = (trim_q != 9'h000) && !trim_pos_q;
  assign swallow = (trim_q != 9'h000) && trim_pos_q;
  assign pre_end = (pre_q == rtc_pkg::PRE_WRAP - {15'h0000, blank});
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_q <= 16'h0000;
      stage_q <= 8'h00;
      trim_q <= 9'h000;
      trim_pos_q <= 1'b0;
    end else if (osc_run_q && osc_tick_i && !ctrl_q[rtc_pkg::CTRL_XFER_BIT]) begin
      if (swallow) begin
        trim_q <= trim_q - 9'h001; // swallow ticks: second lengthened
      end else if (pre_end) begin
        pre_q <= 16'h0000;
        trim_q <= blank ? trim_q - 9'h001 : trim_q;
        if (stage_q == rtc_pkg::STAGE_WRAP) begin
          stage_q <= 8'h00;
          if (!adj_done_q && adj_min && ctrl_q[4:0] != 5'h00) begin
            trim_pos_q <= ctrl_q[rtc_pkg::CTRL_SIGN_BIT];
            trim_q <= ctrl_q[rtc_pkg::CTRL_SIGN_BIT] ? rtc_pkg::POS_TRIM_CYC
              : rtc_pkg::NEG_TRIM_CYC;
          end
        end else begin
          stage_q <= stage_q + 8'h01;
        end
      end else if (blank) begin
        // Blank: two counts per tick; pre_end allows for the odd boundary
        pre_q <= pre_q + 16'h0002;
        trim_q <= trim_q - 9'h001;
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end else if (ctrl_q[rtc_pkg::CTRL_XFER_BIT]) begin
      pre_q <= 16'h0000; // first second after a transfer is a full one
      stage_q <= 8'h00;
      trim_q <= 9'h000;
    end
  end
  assign sec_tick = osc_run_q && osc_tick_i && !ctrl_q[rtc_pkg::CTRL_XFER_BIT]
    && pre_end && (stage_q == rtc_pkg::STAGE_WRAP) && !swallow;

  // BCD counter chain with calendar carries
  logic [7:0] n_sec, n_min, n_hour, n_date, n_month, n_year, n_wday, last_date;
  logic w_sec, w_min, w_hour, w_date, w_month;
  logic leap;
  assign leap = (c_year_q[4] == 1'b0) ? (c_year_q[1:0] == 2'b00 && c_year_q[3:2] != 2'b01
    && c_year_q[3:2] != 2'b11) || (c_year_q[3:0] == 4'h4) || (c_year_q[3:0] == 4'h8)
    : (c_year_q[3:0] == 4'h2) || (c_year_q[3:0] == 4'h6);
  always_comb begin
    case (c_month_q)
      8'h02: last_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  end
  rtc_bcd_inc u_sec (.val_i(c_sec_q), .last_i(rtc_pkg::BCD_59),
    .first_i(rtc_pkg::BCD_00), .next_o(n_sec), .wrap_o(w_sec));
  rtc_bcd_inc u_min (.val_i(c_min_q), .last_i(rtc_pkg::BCD_59),
    .first_i(rtc_pkg::BCD_00), .next_o(n_min), .wrap_o(w_min));
  rtc_bcd_inc u_hour (.val_i(c_hour_q), .last_i(rtc_pkg::BCD_23),
    .first_i(rtc_pkg::BCD_00), .next_o(n_hour), .wrap_o(w_hour));
  rtc_bcd_inc u_date (.val_i(c_date_q), .last_i(last_date),
    .first_i(rtc_pkg::BCD_01), .next_o(n_date), .wrap_o(w_date));
  rtc_bcd_inc u_month (.val_i(c_month_q), .last_i(rtc_pkg::BCD_12),
    .first_i(rtc_pkg::BCD_01), .next_o(n_month), .wrap_o(w_month));
  rtc_bcd_inc u_year (.val_i(c_year_q), .last_i(rtc_pkg::BCD_99),
    .first_i(rtc_pkg::BCD_00), .next_o(n_year), .wrap_o());
  rtc_bcd_inc u_wday (.val_i(c_wday_q), .last_i(rtc_pkg::WDAY_LAST),
    .first_i(rtc_pkg::BCD_01), .next_o(n_wday), .wrap_o());

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      c_sec_q <= 8'h00;
      c_min_q <= 8'h00;
      c_hour_q <= 8'h00;
      c_wday_q <= 8'h01;
      c_date_q <= 8'h01;
      c_month_q <= 8'h01;
      c_year_q <= 8'h00;
    end else if (xfer_fall) begin
      c_sec_q <= r_sec_q;
      c_min_q <= r_min_q;
      c_hour_q <= r_hour_q;
      c_wday_q <= r_wday_q;
      c_date_q <= r_date_q;
      c_month_q <= r_month_q;
      c_year_q <= r_year_q;
    end else if (sec_tick) begin
      c_sec_q <= n_sec;
      if (w_sec) begin
        c_min_q <= n_min;
        if (w_min) begin
          c_hour_q <= n_hour;
          if (w_hour) begin
            c_wday_q <= n_wday;
            c_date_q <= n_date;
            if (w_date) begin
              c_month_q <= n_month;
              if (w_month) begin
                c_year_q <= n_year;
              end
            end
          end
        end
      end
    end
  end

  // Calibration minute within the 64-minute cycle; one adjusted second per minute
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cal_min_q <= 6'h00;
      adj_done_q <= 1'b0;
    end else if (sec_tick) begin
      if (w_sec) begin
        cal_min_q <= cal_min_q + 6'h01; // wraps after 63
        adj_done_q <= 1'b0;
      end else begin
        adj_done_q <= 1'b1;
      end
    end
  end

  // Refresh sequencer: a pending tick loads all registers in one cycle.
  // Holdoff skips the first tick after a halt; a transfer restarts the divider.
  logic halted;
  assign halted = ctrl_q[rtc_pkg::CTRL_HALT_BIT] || ctrl_q[rtc_pkg::CTRL_XFER_BIT];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_q <= RTC_IDLE;
      holdoff_q <= 1'b0;
    end else begin
      case (ref_q)
        RTC_IDLE: begin
          if (sec_tick && !halted) begin
            if (holdoff_q) begin
              holdoff_q <= 1'b0;
            end else begin
              ref_q <= RTC_LOAD;
            end
          end
        end
        RTC_LOAD: begin
          ref_q <= RTC_WAIT; // load completes regardless of halt
        end
        RTC_WAIT: begin
          ref_q <= RTC_IDLE;
        end
        default: ref_q <= RTC_IDLE;
      endcase
      if (ctrl_q[rtc_pkg::CTRL_HALT_BIT]) begin
        holdoff_q <= 1'b1;
      end
    end
  end

  // Time registers: refreshed from counters or written by software
  logic load;
  assign load = (ref_q == RTC_LOAD);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r_sec_q <= 8'h00;
      r_min_q <= 8'h00;
      r_hour_q <= 8'h00;
      r_wday_q <= 8'h01;
      r_date_q <= 8'h01;
      r_month_q <= 8'h01;
      r_year_q <= 8'h00;
    end else if (load) begin
      // Counters are stable here: the tick that armed the load passed one cycle ago
      r_sec_q <= c_sec_q;
      r_min_q <= c_min_q;
      r_hour_q <= c_hour_q;
      r_wday_q <= c_wday_q;
      r_date_q <= c_date_q;
      r_month_q <= c_month_q;
      r_year_q <= c_year_q;
    end else if (sel_i && wr_i) begin
      // Software writes BCD, 24-hour; fixed-zero bits dropped on entry
      if (addr_i == rtc_pkg::ADDR_SEC) begin
        r_sec_q <= wdata_i & rtc_pkg::MASK_SEC;
      end else if (addr_i == rtc_pkg::ADDR_MIN) begin
        r_min_q <= wdata_i & rtc_pkg::MASK_MIN;
      end else if (addr_i == rtc_pkg::ADDR_HOUR) begin
        r_hour_q <= wdata_i & rtc_pkg::MASK_HOUR;
      end else if (addr_i == rtc_pkg::ADDR_WDAY) begin
        r_wday_q <= wdata_i & rtc_pkg::MASK_WDAY;
      end else if (addr_i == rtc_pkg::ADDR_DATE) begin
        r_date_q <= wdata_i & rtc_pkg::MASK_DATE;
      end else if (addr_i == rtc_pkg::ADDR_MONTH) begin
        r_month_q <= wdata_i & rtc_pkg::MASK_MONTH;
      end else if (addr_i == rtc_pkg::ADDR_YEAR) begin
        r_year_q <= wdata_i & rtc_pkg::MASK_YEAR;
      end
    end
  end

  // Read port, registered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= sel_i && !wr_i;
      if (!(sel_i && !wr_i)) begin
        rdata_o <= 8'h00;
      end else if (addr_i == rtc_pkg::ADDR_CTRL) begin
        rdata_o <= ctrl_q;
      end else if (addr_i == rtc_pkg::ADDR_SEC) begin
        rdata_o <= {osc_halt_bit_q, r_sec_q[6:0]};
      end else if (addr_i == rtc_pkg::ADDR_MIN) begin
        rdata_o <= r_min_q;
      end else if (addr_i == rtc_pkg::ADDR_HOUR) begin
        rdata_o <= r_hour_q;
      end else if (addr_i == rtc_pkg::ADDR_WDAY) begin
        rdata_o <= r_wday_q;
      end else if (addr_i == rtc_pkg::ADDR_DATE) begin
        rdata_o <= r_date_q;
      end else if (addr_i == rtc_pkg::ADDR_MONTH) begin
        rdata_o <= r_month_q;
      end else if (addr_i == rtc_pkg::ADDR_YEAR) begin
        rdata_o <= r_year_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_run_o <= 1'b0;
      sec_pulse_o <= 1'b0;
    end else begin
      osc_run_o <= osc_run_q;
      sec_pulse_o <= sec_tick;
    end
  end
endmodule : rtc_core
`default_nettype wire

// file: core/rtc_pkg.sv
/*
  Constants for the BCD calendar clock register block: register offsets,
  control field positions, divider and calibration figures.
  Assumes a single 10 MHz system clock and a 32,768 Hz oscillator tick input.
*/
package rtc_pkg;
  localparam logic [18:0] ADDR_CTRL = 19'h7_fff8;
  localparam logic [18:0] ADDR_SEC = 19'h7_fff9;
  localparam logic [18:0] ADDR_MIN = 19'h7_fffa;
  localparam logic [18:0] ADDR_HOUR = 19'h7_fffb;
  localparam logic [18:0] ADDR_WDAY = 19'h7_fffc;
  localparam logic [18:0] ADDR_DATE = 19'h7_fffd;
  localparam logic [18:0] ADDR_MONTH = 19'h7_fffe;
  localparam logic [18:0] ADDR_YEAR = 19'h7_ffff;

  localparam int CTRL_XFER_BIT = 7;
  localparam int CTRL_HALT_BIT = 6;
  localparam int CTRL_SIGN_BIT = 5;
  localparam int SEC_OSC_HALT_BIT = 7;

  // Write masks: fixed-zero bits of each time byte, dropped on entry
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;

  // Oscillator divider
  localparam int OSC_HZ = 32768;
  localparam logic [15:0] PRE_WRAP = 16'h00ff;    // Divide-by-256 stage
  localparam logic [7:0] STAGE_WRAP = 8'h7f;      // 128 stage ticks per second
  localparam logic [8:0] NEG_TRIM_CYC = 9'h080;   // 128 cycles dropped
  localparam logic [8:0] POS_TRIM_CYC = 9'h100;   // 256 cycles added
  localparam logic [5:0] CAL_CYCLE_MIN = 6'h3f;   // 64-minute cycle wrap
  localparam int OSC_START_SEC = 1;

  // BCD limits
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] WDAY_LAST = 8'h07;
endpackage : rtc_pkg

// file: verification/rtc_core_props.sv
/* Port checker for rtc_core: bus answers, read-back masks, oscillator
   stop and start, second spacing and held time while halted.
   Assumes one clock and osc ticks that keep coming while running. */
`timescale 1ns/100ps
`default_nettype none
module rtc_core_props #(
  parameter int OSC_HZ = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic osc_tick_i,
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic osc_run_o,
  input wire logic sec_pulse_o
);
  localparam int MIN_TK = 32638;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd, wsec, wctl, halt_q, stop_q, have_q, seen_q;
  logic [18:0] ra_q;
  logic [3:0] age_q;
  logic [7:0] last_q;
  logic [16:0] tk_q;
  assign rd = sel_i && !wr_i;
  assign wsec = sel_i && wr_i && addr_i == rtc_pkg::ADDR_SEC;
  assign wctl = sel_i && wr_i && addr_i == rtc_pkg::ADDR_CTRL;
  function automatic logic [7:0] mask(input logic [18:0] a);
    case (a)
      19'h7_fff8, 19'h7_fff9, 19'h7_ffff: mask = 8'hff;
      19'h7_fffa: mask = 8'h7f;
      19'h7_fffb, 19'h7_fffd: mask = 8'h3f;
      19'h7_fffc: mask = 8'h07;
      19'h7_fffe: mask = 8'h1f;
      default: mask = 8'h00;
    endcase
  endfunction : mask
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ra_q <= '0;
      halt_q <= 1'b0;
      stop_q <= 1'b0;
      age_q <= '0;
    end else begin
      if (rd) ra_q <= addr_i;
      if (wctl) halt_q <= wdata_i[6];
      if (wsec) stop_q <= wdata_i[7];
      if (wctl) age_q <= '0;
      else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    end
  end
  // Reference read is taken only once any refresh in flight has landed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wctl || wsec) begin
      have_q <= 1'b0;
      last_q <= '0;
    end else if (rvalid_o && ra_q == rtc_pkg::ADDR_SEC && halt_q && age_q == 4'hf) begin
      have_q <= 1'b1;
      last_q <= rdata_o;
    end
  end
  // Stops and transfers only lengthen a second, so only a floor is safe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tk_q <= '0;
      seen_q <= 1'b0;
    end else if (sec_pulse_o) begin
      tk_q <= '0;
      seen_q <= 1'b1;
    end else if (osc_tick_i && tk_q != 17'h1_ffff) begin
      tk_q <= tk_q + 17'h0_0001;
    end
  end
  property p_read_answer; rd |=> rvalid_o; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_extra; !rd |=> !rvalid_o; endproperty
  a_no_extra: assert property (p_no_extra) else $error("read valid without read");
  property p_idle_zero; !rvalid_o |-> rdata_o == 8'h00; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
  property p_fixed_zero; rvalid_o |-> (rdata_o & ~mask(ra_q)) == 8'h00; endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed zero bit set");
  property p_osc_stop; wsec && wdata_i[7] |-> ##[1:3] !osc_run_o; endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator kept running");
  property p_stop_hold; stop_q && $past(stop_q, 2) |-> !osc_run_o && !sec_pulse_o; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("activity while stopped");
  property p_osc_start;
    stop_q && wsec && !wdata_i[7] |=> !osc_run_o [*2] ##[1:200] osc_run_o;
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("restart timing wrong");
  property p_sec_len; sec_pulse_o && seen_q |-> tk_q >= MIN_TK; endproperty
  a_sec_len: assert property (p_sec_len) else $error("second too short");
  property p_halt_hold;
    have_q && halt_q && rvalid_o && ra_q == rtc_pkg::ADDR_SEC |-> rdata_o == last_q;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("time changed while halted");
  c_read: cover property (rd ##1 rvalid_o);
  c_second: cover property (sec_pulse_o && seen_q);
  c_restart: cover property (stop_q ##1 !stop_q ##[1:200] $rose(osc_run_o));
  c_halted_read: cover property (have_q && rvalid_o);
endmodule : rtc_core_props
bind rtc_core rtc_core_props #(.OSC_HZ(OSC_HZ)) i_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .osc_tick_i(osc_tick_i), .sel_i(sel_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .osc_run_o(osc_run_o), .sec_pulse_o(sec_pulse_o));
`default_nettype wire

// file: verification/rtc_host.sv
/* Host processor model: byte reads and writes on the core's register bus.
   Assumes calls start only after reset is released. */
`timescale 1ns/100ps
`default_nettype none
module rtc_host (
  // Clock
  input wire logic clk_i,
  // Answer
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  // Request
  output logic sel_o,
  output logic wr_o,
  output logic [18:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    sel_o = 1'b0;
    wr_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end
  // Callers pass time values in BCD with hours 00 to 23; released lines flip
  task automatic write(input logic [18:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sel_o <= 1'b1;
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    sel_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : write
  task automatic read(input logic [18:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    sel_o <= 1'b1;
    wr_o <= 1'b0;
    addr_o <= a;
    @(posedge clk_i);
    sel_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask : read
endmodule : rtc_host
`default_nettype wire

// file: verification/test_bcd_calendar_clock_regs.sv
/* Testbench for rtc_core: reset values, oscillator stop and start,
   time transfer, calendar carry, halted reads and a second reset.
   Assumes one oscillator tick per clock, so a second is 32768 cycles. */
`timescale 1ns/100ps
`default_nettype none
module test_bcd_calendar_clock_regs;
  typedef struct {logic [18:0] a; logic [7:0] rst; logic [7:0] set; logic [7:0] back;
    logic [7:0] aft;} rtc_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic osc_tick_i = 1'b1;
  logic sel_i, wr_i, rvalid_o, osc_run_o, sec_pulse_o;
  logic [18:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  int num_errors = 0;
  int num_checks = 0;
  logic [16:0] gap_q = '0;
  logic [16:0] last_gap_q = '0;
  // Set 23:59:59 on 28 Feb of a leap year, weekday 7; two seconds later
  rtc_row_t rows[7] = '{
    '{19'h7_fff9, 8'h00, 8'h59, 8'h59, 8'h01}, '{19'h7_fffa, 8'h00, 8'h59, 8'h59, 8'h00},
    '{19'h7_fffb, 8'h00, 8'h23, 8'h23, 8'h00}, '{19'h7_fffc, 8'h01, 8'hff, 8'h07, 8'h01},
    '{19'h7_fffd, 8'h01, 8'h28, 8'h28, 8'h29}, '{19'h7_fffe, 8'h01, 8'h02, 8'h02, 8'h02},
    '{19'h7_ffff, 8'h00, 8'h04, 8'h04, 8'h04}};
  always #50 clk_i = ~clk_i;
  // Clock edges between the last two second pulses, for the calibration checks
  always @(posedge clk_i) begin
    if (sec_pulse_o) begin
      last_gap_q <= gap_q;
      gap_q <= 17'h0_0001;
    end else if (gap_q != 17'h1_ffff) begin
      gap_q <= gap_q + 17'h0_0001;
    end
  end
  rtc_host i_host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .sel_o(sel_i),
    .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
  rtc_core #(.OSC_HZ(4)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .osc_tick_i(osc_tick_i),
    .sel_i(sel_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .osc_run_o(osc_run_o), .sec_pulse_o(sec_pulse_o));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic gap_chk(input string n, input logic [16:0] e);
    num_checks++;
    if (last_gap_q !== e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", n, e, last_gap_q);
    end
  endtask : gap_chk
  task automatic rd_chk(input string n, input logic [18:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host.read(a, d, v);
    check({n, " valid"}, 8'h01, {7'h00, v});
    check(n, e, d);
  endtask : rd_chk
  task automatic wait_sec();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (sec_pulse_o !== 1'b1 && n < 40000);
    check("second pulse", 8'h01, {7'h00, sec_pulse_o});
    repeat (4) @(posedge clk_i);
  endtask : wait_sec
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    int n;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("control", 19'h7_fff8, 8'h00);
    rd_chk("unmapped", 19'h0_0000, 8'h00);
    foreach (rows[i]) rd_chk("reset value", rows[i].a, rows[i].rst);
    $display("test done: reset values");
    i_host.write(19'h7_fff9, 8'h80);
    repeat (2) @(posedge clk_i);
    #1;
    check("osc run", 8'h00, {7'h00, osc_run_o});
    rd_chk("stop bit", 19'h7_fff9, 8'h80);
    i_host.write(19'h7_fff9, 8'h00);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (osc_run_o !== 1'b1 && n < 50);
    check("osc restart", 8'h01, {7'h00, osc_run_o});
    $display("test done: oscillator stop and start");
    i_host.write(19'h7_fff8, 8'h3f);
    rd_chk("calibration", 19'h7_fff8, 8'h3f);
    i_host.write(19'h7_fff8, 8'h81);
    foreach (rows[i]) i_host.write(rows[i].a, rows[i].set);
    foreach (rows[i]) rd_chk("loaded", rows[i].a, rows[i].back);
    i_host.write(19'h7_fff8, 8'h01);
    // The divider restarts at the transfer, so its first tick refreshes
    wait_sec();
    rd_chk("first second", 19'h7_fff9, 8'h00);
    // Magnitude 1 negative shortens the next second, then positive lengthens one
    i_host.write(19'h7_fff8, 8'h21);
    wait_sec();
    gap_chk("short second", 17'h0_7f80);
    foreach (rows[i]) rd_chk("refreshed", rows[i].a, rows[i].aft);
    $display("test done: transfer and calendar carry");
    i_host.write(19'h7_fff8, 8'h40);
    wait_sec();
    gap_chk("long second", 17'h0_8100);
    repeat (2) rd_chk("halted", 19'h7_fff9, 8'h01);
    $display("test done: halted reads");
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("control after reset", 19'h7_fff8, 8'h00);
    $display("test done: second reset");
    conclude();
  end
endmodule : test_bcd_calendar_clock_regs
`default_nettype wire
